// ---- hw/spc_pkg.sv ----
package spc_pkg;

  // sizes
  localparam int NPORT = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CW = 9;
  localparam int IRQ_W = 2 * NPORT;

  // register map: per port block selected by address bits 6:5, globals above
  localparam int GLOBAL_SEL_BIT = 7;
  localparam int PORT_SEL_LSB = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_CLKDIV = 5'h08;
  localparam logic [4:0] OFF_TIMER = 5'h0C;
  localparam logic [4:0] OFF_TXD = 5'h10;
  localparam logic [4:0] OFF_RXD = 5'h14;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h80;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h84;

  // field positions
  localparam int CTRL_LOOP_BIT = 22;
  localparam int CTRL_RMAP_BIT = 16;
  localparam int CTRL_ADDR_LSB = 0;
  localparam int STAT_TXBUSY_BIT = 0;
  localparam int STAT_RXFULL_BIT = 1;
  localparam int STAT_WSYNC_BIT = 6;
  localparam int STAT_ERR_LSB = 8;
  localparam int DIV_START_LSB = 0;
  localparam int RXD_VALID_BIT = 9;
  localparam int CHAR_FLAG_BIT = 8;

  // reset values and codes
  localparam logic [7:0] CLKDIV_RST = 8'h09;
  localparam logic [7:0] NODE_ADDR_RST = 8'hFE;
  localparam logic [7:0] RMAP_PROTO = 8'h01;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_INV_DEST = 8'h0C;
  localparam logic [3:0] CHAR_BITS = 4'h9;
  localparam logic [3:0] CHAR_LAST = 4'h8;

  // remote node bit time
  localparam int MCLK_NS = 8;
  localparam int NODE_BIT_NS = 160;
  localparam int NODE_BIT_CYC = (NODE_BIT_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [4:0] NODE_DIV_LAST = 5'(NODE_BIT_CYC - 1);

  // position inside an incoming packet
  typedef enum logic [2:0] {
    RM_DEST = 3'b001,
    RM_PROTO = 3'b010,
    RM_BODY = 3'b100
  } spc_rmap_e;

  typedef struct packed {
    logic loop_en;
    logic rmap_en;
    logic [7:0] node_addr;
    logic [7:0] clkdiv;
    logic [7:0] divcnt;
    logic [1:0] ds1;
    logic [1:0] ds2;
    logic tx_d;
    logic tx_s;
    logic [CW-1:0] tx_sh;
    logic [3:0] tx_cnt;
    logic rx_par;
    logic [CW-1:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [CW-1:0] rx_char;
    logic rx_full;
    spc_rmap_e rm;
    logic [7:0] dest;
    logic [7:0] err;
  } spc_port_s;

  typedef struct packed {
    spc_port_s [NPORT-1:0] port;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DW-1:0] rdata;
    logic irq;
  } spc_dev_s;

  typedef struct packed {
    logic [1:0] ds1;
    logic [1:0] ds2;
    logic tx_d;
    logic tx_s;
    logic [CW-1:0] tx_sh;
    logic [3:0] tx_cnt;
    logic tx_ready;
    logic rx_par;
    logic [CW-1:0] rx_sh;
    logic [3:0] rx_cnt;
    logic rx_valid;
    logic [CW-1:0] rx_char;
  } spc_lane_s;

  typedef struct packed {
    spc_lane_s [NPORT-1:0] lane;
    logic [4:0] divcnt;
  } spc_node_s;

  // data-strobe step: data carries the bit, strobe toggles when data does not
  function automatic logic [1:0] ds_encode(input logic [1:0] ds, input logic b);
    ds_encode = {b, (b == ds[1]) ? ~ds[0] : ds[0]};
  endfunction

endpackage

// ---- hw/spc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// data and strobe lines of four links, one bit per port
interface spc_link_if;
  logic [spc_pkg::NPORT-1:0] dev_d;
  logic [spc_pkg::NPORT-1:0] dev_s;
  logic [spc_pkg::NPORT-1:0] node_d;
  logic [spc_pkg::NPORT-1:0] node_s;
  modport dev (output dev_d, output dev_s, input node_d, input node_s);
  modport node (input dev_d, input dev_s, output node_d, output node_s);
endinterface
`default_nettype wire

// ---- hw/spc_node.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_node (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user transmit side, one lane per port
  input wire logic [spc_pkg::NPORT-1:0] tx_valid,
  input wire logic [spc_pkg::NPORT-1:0][spc_pkg::CW-1:0] tx_char,
  output logic [spc_pkg::NPORT-1:0] tx_ready,
  // user receive side
  output logic [spc_pkg::NPORT-1:0] rx_valid,
  output logic [spc_pkg::NPORT-1:0][spc_pkg::CW-1:0] rx_char,
  // link
  spc_link_if.node link
);

  spc_pkg::spc_node_s s;
  spc_pkg::spc_node_s next_s;

  // next state of all lanes
  always_comb begin
    spc_pkg::spc_lane_s c;
    spc_pkg::spc_lane_s q;
    logic tick;
    logic [spc_pkg::CW-1:0] ch;
    c = '0;
    q = '0;
    ch = '0;
    next_s = s;
    // one bit time shared by all lanes
    tick = (s.divcnt == '0);
    next_s.divcnt = tick ? spc_pkg::NODE_DIV_LAST : s.divcnt - 5'h01;
    for (int p = 0; p < spc_pkg::NPORT; p++) begin
      c = s.lane[p];
      q = c;
      q.ds1 = {link.dev_d[p], link.dev_s[p]};
      q.ds2 = c.ds1;
      q.rx_valid = 1'b0;
      // bit spacing kept slow
      // the device samples once per its tick; bits stay 20 cycles apart, no closer than a tick for a divisor up to 19
      if (tick && c.tx_cnt != '0) begin
        {q.tx_d, q.tx_s} = spc_pkg::ds_encode({c.tx_d, c.tx_s}, c.tx_sh[0]);
        q.tx_sh = {1'b0, c.tx_sh[spc_pkg::CW-1:1]};
        q.tx_cnt = c.tx_cnt - 4'h1;
      end
      if (tx_valid[p] && c.tx_ready) begin
        q.tx_sh = tx_char[p];
        q.tx_cnt = spc_pkg::CHAR_BITS;
      end
      q.tx_ready = (q.tx_cnt == '0);
      // receiver: every parity change of data and strobe is a new bit
      if ((c.ds2[1] ^ c.ds2[0]) != c.rx_par) begin
        q.rx_par = ~c.rx_par;
        ch = {c.ds2[1], c.rx_sh[spc_pkg::CW-1:1]};
        q.rx_sh = ch;
        if (c.rx_cnt == spc_pkg::CHAR_LAST) begin
          q.rx_cnt = '0;
          q.rx_char = ch;
          q.rx_valid = 1'b1;
        end else begin
          q.rx_cnt = c.rx_cnt + 4'h1;
        end
      end
      next_s.lane[p] = q;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      for (int p = 0; p < spc_pkg::NPORT; p++) begin
        s.lane[p].tx_ready <= 1'b1;
      end
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state
  for (genvar g = 0; g < spc_pkg::NPORT; g++) begin : g_out
    assign link.node_d[g] = s.lane[g].tx_d;
    assign link.node_s[g] = s.lane[g].tx_s;
    assign tx_ready[g] = s.lane[g].tx_ready;
    assign rx_valid[g] = s.lane[g].rx_valid;
    assign rx_char[g] = s.lane[g].rx_char;
  end

endmodule // spc_node
`default_nettype wire

// ---- hw/spc_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_dev (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [spc_pkg::AW-1:0] reg_addr,
  input wire logic [spc_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [spc_pkg::DW-1:0] reg_rdata,
  // interrupt
  output logic irq,
  // link
  spc_link_if.dev link
);

  spc_pkg::spc_dev_s s;
  spc_pkg::spc_dev_s next_s;

  // register hit for one port block
  function automatic logic port_hit(input logic [spc_pkg::AW-1:0] a, input int p,
                                    input logic [4:0] off);
    port_hit = !a[spc_pkg::GLOBAL_SEL_BIT]
      && (a[spc_pkg::PORT_SEL_LSB +: 2] == 2'(p))
      && (a[spc_pkg::PORT_SEL_LSB-1:0] == off);
  endfunction

  // next state: bus accesses first so that link events win over clears
  always_comb begin
    spc_pkg::spc_port_s c;
    spc_pkg::spc_port_s q;
    logic tick;
    logic [1:0] ds;
    logic [spc_pkg::CW-1:0] ch;
    logic [spc_pkg::DW-1:0] w;
    logic [spc_pkg::IRQ_W-1:0] ev;
    c = '0;
    q = '0;
    tick = 1'b0;
    ds = '0;
    ch = '0;
    w = '0;
    ev = '0;
    next_s = s;
    next_s.rdata = '0;

    // global registers
    if (reg_wr && reg_addr == spc_pkg::ADDR_IRQ_MASK) begin
      next_s.irq_mask = reg_wdata[spc_pkg::IRQ_W-1:0];
    end
    if (reg_rd && reg_addr == spc_pkg::ADDR_IRQ_STAT) begin
      next_s.rdata = {{(spc_pkg::DW-spc_pkg::IRQ_W){1'b0}}, s.irq_stat};
    end
    if (reg_rd && reg_addr == spc_pkg::ADDR_IRQ_MASK) begin
      next_s.rdata = {{(spc_pkg::DW-spc_pkg::IRQ_W){1'b0}}, s.irq_mask};
    end

    for (int p = 0; p < spc_pkg::NPORT; p++) begin
      c = s.port[p];
      q = c;
      // two flops on the pins; only the second is used below
      q.ds1 = {link.node_d[p], link.node_s[p]};
      q.ds2 = c.ds1;

      if (reg_wr && port_hit(reg_addr, p, spc_pkg::OFF_CTRL)) begin
        q.loop_en = reg_wdata[spc_pkg::CTRL_LOOP_BIT];
        q.rmap_en = reg_wdata[spc_pkg::CTRL_RMAP_BIT];
        q.node_addr = reg_wdata[spc_pkg::CTRL_ADDR_LSB +: 8];
      end
      if (reg_wr && port_hit(reg_addr, p, spc_pkg::OFF_CLKDIV)) begin
        q.clkdiv = reg_wdata[spc_pkg::DIV_START_LSB +: 8];
      end
      // status write ignores bit 6
      // any status write only clears the error code field
      if (reg_wr && port_hit(reg_addr, p, spc_pkg::OFF_STAT)) begin
        q.err = spc_pkg::ERR_NONE;
      end
      // a character written while busy is dropped; poll the busy bit first
      if (reg_wr && port_hit(reg_addr, p, spc_pkg::OFF_TXD) && c.tx_cnt == '0) begin
        q.tx_sh = reg_wdata[spc_pkg::CW-1:0];
        q.tx_cnt = spc_pkg::CHAR_BITS;
      end
      if (reg_rd && port_hit(reg_addr, p, spc_pkg::OFF_RXD)) begin
        q.rx_full = 1'b0;
      end

      // read data of this port block
      w = '0;
      if (port_hit(reg_addr, p, spc_pkg::OFF_CTRL)) begin
        w[spc_pkg::CTRL_LOOP_BIT] = c.loop_en;
        w[spc_pkg::CTRL_RMAP_BIT] = c.rmap_en;
        w[spc_pkg::CTRL_ADDR_LSB +: 8] = c.node_addr;
      end
      if (port_hit(reg_addr, p, spc_pkg::OFF_STAT)) begin
        w[spc_pkg::STAT_TXBUSY_BIT] = (c.tx_cnt != '0);
        w[spc_pkg::STAT_RXFULL_BIT] = c.rx_full;
        w[spc_pkg::STAT_WSYNC_BIT] = 1'b0;
        w[spc_pkg::STAT_ERR_LSB +: 8] = c.err;
      end
      if (port_hit(reg_addr, p, spc_pkg::OFF_CLKDIV)) begin
        w[spc_pkg::DIV_START_LSB +: 8] = c.clkdiv;
      end
      // timer register reads zero
      // the timer offset has no decode and stores nothing, so w stays zero
      if (port_hit(reg_addr, p, spc_pkg::OFF_RXD)) begin
        w[spc_pkg::RXD_VALID_BIT] = c.rx_full;
        w[spc_pkg::CW-1:0] = c.rx_char;
      end
      if (reg_rd && !reg_addr[spc_pkg::GLOBAL_SEL_BIT]
          && reg_addr[spc_pkg::PORT_SEL_LSB +: 2] == 2'(p)) begin
        next_s.rdata = w;
      end

      // divider from startup field
      // reload from the register so a new divisor acts after the current period
      tick = (c.divcnt == '0);
      q.divcnt = tick ? c.clkdiv : c.divcnt - 8'h01;

      if (tick && c.tx_cnt != '0) begin
        {q.tx_d, q.tx_s} = spc_pkg::ds_encode({c.tx_d, c.tx_s}, c.tx_sh[0]);
        q.tx_sh = {1'b0, c.tx_sh[spc_pkg::CW-1:1]};
        q.tx_cnt = c.tx_cnt - 4'h1;
      end

      // internal loopback select
      // pins keep being driven in loopback; the remote end just sees traffic
      ds = c.loop_en ? {c.tx_d, c.tx_s} : c.ds2;

      // tick samples receiver
      // at most one bit per tick, so the far end must not send faster
      if (tick && (ds[1] ^ ds[0]) != c.rx_par) begin
        q.rx_par = ~c.rx_par;
        ch = {ds[1], c.rx_sh[spc_pkg::CW-1:1]};
        q.rx_sh = ch;
        if (c.rx_cnt == spc_pkg::CHAR_LAST) begin
          q.rx_cnt = '0;
          q.rx_char = ch;
          q.rx_full = 1'b1;
          ev[p] = 1'b1;
          if (ch[spc_pkg::CHAR_FLAG_BIT]) begin
            // a control character ends the packet
            q.rm = spc_pkg::RM_DEST;
          end else begin
            case (c.rm)
              spc_pkg::RM_DEST: begin
                q.dest = ch[7:0];
                q.rm = spc_pkg::RM_PROTO;
              end
              spc_pkg::RM_PROTO: begin
                q.rm = spc_pkg::RM_BODY;
                if (c.rmap_en && ch[7:0] == spc_pkg::RMAP_PROTO
                    && c.dest != c.node_addr) begin
                  q.err = spc_pkg::ERR_INV_DEST;
                  ev[spc_pkg::NPORT+p] = 1'b1;
                end
              end
              spc_pkg::RM_BODY: begin
                q.rm = spc_pkg::RM_BODY;
              end
              default: begin
                q.rm = spc_pkg::RM_DEST;
              end
            endcase
          end
        end else begin
          q.rx_cnt = c.rx_cnt + 4'h1;
        end
      end

      // loop switch resyncs receiver
      // the parity jump between the two sources would otherwise read as a stray bit;
      // a half-received character is dropped, so switch only while the link is quiet
      if (q.loop_en != c.loop_en) begin
        q.rx_par = q.loop_en ? (q.tx_d ^ q.tx_s) : (q.ds2[1] ^ q.ds2[0]);
        q.rx_cnt = '0;
      end
      next_s.port[p] = q;
    end

    // sticky status: read clears, a same-cycle event still lands
    if (reg_rd && reg_addr == spc_pkg::ADDR_IRQ_STAT) begin
      next_s.irq_stat = ev;
    end else begin
      next_s.irq_stat = s.irq_stat | ev;
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      for (int p = 0; p < spc_pkg::NPORT; p++) begin
        s.port[p].clkdiv <= spc_pkg::CLKDIV_RST;
        s.port[p].node_addr <= spc_pkg::NODE_ADDR_RST;
        s.port[p].rm <= spc_pkg::RM_DEST;
      end
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state
  assign reg_rdata = s.rdata;
  assign irq = s.irq;
  for (genvar g = 0; g < spc_pkg::NPORT; g++) begin : g_pin
    assign link.dev_d[g] = s.port[g].tx_d;
    assign link.dev_s[g] = s.port[g].tx_s;
  end

endmodule // spc_dev
`default_nettype wire

// ---- test/spc_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link lines of both ends
  input wire logic [spc_pkg::NPORT-1:0] dev_d,
  input wire logic [spc_pkg::NPORT-1:0] dev_s,
  input wire logic [spc_pkg::NPORT-1:0] node_d,
  input wire logic [spc_pkg::NPORT-1:0] node_s
);
  logic [3:0] pdd, pds, pnd, pns;
  logic [7:0] ng;
  logic [3:0][7:0] dg;
  logic nchg;
  logic [3:0] dchg;
  // line changes against the previous cycle
  assign dchg = (dev_d ^ pdd) | (dev_s ^ pds);
  assign nchg = |((node_d ^ pnd) | (node_s ^ pns));
  // gap counters saturate so a quiet link never wraps into a false short gap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pdd, pds, pnd, pns} <= '0;
      ng <= 8'hFF;
      dg <= '1;
    end else begin
      {pdd, pds, pnd, pns} <= {dev_d, dev_s, node_d, node_s};
      ng <= nchg ? 8'h01 : ((ng == 8'hFF) ? ng : ng + 8'h01);
      for (int p = 0; p < 4; p++) begin
        dg[p] <= dchg[p] ? 8'h01 : ((dg[p] == 8'hFF) ? dg[p] : dg[p] + 8'h01);
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  dev_rst_idle_a: assert property ($rose(rst_n) |-> (dev_d | dev_s) == 4'h0)
    else $error("device lines not idle after reset");
  node_rst_idle_a: assert property ($rose(rst_n) |-> (node_d | node_s) == 4'h0)
    else $error("node lines not idle after reset");
  dev_one_line_a: assert property (((dev_d ^ pdd) & (dev_s ^ pds)) == 4'h0)
    else $error("device moved data and strobe together");
  node_one_line_a: assert property (((node_d ^ pnd) & (node_s ^ pns)) == 4'h0)
    else $error("node moved data and strobe together");
  node_gap_a: assert property (nchg |-> ng >= 8'd20)
    else $error("node bits closer than its tick");
  node_grid_a: assert property (nchg && ng != 8'hFF |-> (ng % 8'd20) == 8'd0)
    else $error("node bit off the shared tick grid");
  node_hold_a: assert property (nchg |=> !nchg [*8])
    else $error("node lines moved again too soon");
  // every divisor the bench programs gives at least two cycles per bit
  for (genvar p = 0; p < 4; p++) begin : g_port
    dev_gap_a: assert property (dchg[p] |-> dg[p] >= 8'h02)
      else $error("device bits closer than its tick");
  end
endmodule // spc_sva
`default_nettype wire

// ---- test/spacewire_port_ctrl_status_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spacewire_port_ctrl_status_test;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd_val;
  logic irq;
  logic [3:0] tx_valid = 4'h0;
  logic [3:0][8:0] tx_char = '0;
  logic [3:0] tx_ready, rx_valid;
  logic [3:0][8:0] rx_char;
  int mismatches = 0;
  int num_checks = 0;
  spc_link_if spc_link_if_i ();
  spc_dev spc_dev_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .link(spc_link_if_i));
  spc_node spc_node_i (.mclk(mclk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_char(tx_char),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_char(rx_char), .link(spc_link_if_i));
  spc_sva spc_sva_i (.mclk(mclk), .rst_n(rst_n), .dev_d(spc_link_if_i.dev_d),
    .dev_s(spc_link_if_i.dev_s), .node_d(spc_link_if_i.node_d), .node_s(spc_link_if_i.node_s));
  // 8 ns clock
  always #4 mclk = ~mclk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ra(input int p, input logic [4:0] off);
    return {1'b0, 2'(p), off};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // rdy picks the node's transmit ready, else its receive pulse
  task automatic wait_lane(input int p, input logic rdy);
    for (int n = 0; n < 800; n++) begin
      @(posedge mclk);
      if ((rdy ? tx_ready[p] : rx_valid[p]) === 1'b1) begin
        return;
      end
    end
    mismatches++;
    print_verdict();
  endtask
  task automatic node_send(input int p, input logic [8:0] c);
    @(posedge mclk);
    tx_valid[p] <= 1'b1;
    tx_char[p] <= c;
    wait_lane(p, 1'b1);
    tx_valid[p] <= 1'b0;
  endtask
  // last bit still needs two sync flops and one device tick
  task automatic node_done(input int p);
    wait_lane(p, 1'b1);
    repeat (16) @(posedge mclk);
  endtask
  task automatic s_reset();
    for (int p = 0; p < 4; p++) begin
      rd(ra(p, 5'h00));
      chk(rd_val, 32'h000000FE);
      rd(ra(p, 5'h08));
      chk(rd_val, 32'h00000009);
      rd(ra(p, 5'h04));
      chk(rd_val, 32'h0);
    end
    rd(8'h84);
    chk(rd_val, 32'h0);
    rd(8'h88);
    chk(rd_val, 32'h0);
  endtask
  task automatic s_retired();
    wr(ra(1, 5'h0C), 32'hFFFFFFFF);
    rd(ra(1, 5'h0C));
    chk(rd_val, 32'h0);
    wr(ra(1, 5'h04), 32'hFFFFFFFF);
    rd(ra(1, 5'h04));
    chk(rd_val, 32'h0);
  endtask
  task automatic s_dev_tx();
    logic [8:0] c;
    for (int p = 0; p < 4; p++) begin
      c = 9'(32'h0A5 + p * 32'h0A1);
      wr(ra(p, 5'h08), 32'(p + 2));
      wr(ra(p, 5'h10), {23'h0, c});
      rd(ra(p, 5'h04));
      chk(rd_val & 32'h41, 32'h01);
      wait_lane(p, 1'b0);
      chk({23'h0, rx_char[p]}, {23'h0, c});
    end
  endtask
  task automatic s_irq();
    rd(8'h80);
    wr(8'h84, 32'h0);
    node_send(2, 9'h03C);
    node_done(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'h80);
    chk(rd_val, 32'h04);
    wr(8'h84, 32'h02);
    node_send(1, 9'h0C3);
    node_done(1);
    chk({31'h0, irq}, 32'h1);
    rd(ra(1, 5'h14));
    chk(rd_val, 32'h2C3);
    rd(8'h80);
    chk(rd_val, 32'h02);
    @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h0);
  endtask
  task automatic rmap_pkt(input int p, input logic [8:0] dest);
    node_send(p, 9'h100);
    node_send(p, dest);
    node_send(p, 9'h001);
    node_send(p, 9'h100);
    node_done(p);
    rd(ra(p, 5'h04));
  endtask
  task automatic s_rmap();
    for (int p = 0; p < 4; p++) begin
      // port 3 leaves checking off, so a foreign destination passes quietly
      wr(ra(p, 5'h00), (p == 3) ? 32'h0FE : 32'h100FE);
      rmap_pkt(p, 9'h033);
      chk(rd_val & 32'hFF40, (p == 3) ? 32'h0 : 32'h0C00);
    end
    rd(8'h80);
    chk(rd_val & 32'hF0, 32'h70);
    wr(ra(0, 5'h04), 32'h0);
    rmap_pkt(0, 9'h0FE);
    chk(rd_val & 32'hFF40, 32'h0);
  endtask
  task automatic s_loop();
    wr(ra(0, 5'h00), 32'h4000FE);
    wr(ra(0, 5'h10), 32'h05A);
    wait_lane(0, 1'b0);
    chk({23'h0, rx_char[0]}, 32'h05A);
    rd(ra(0, 5'h14));
    chk(rd_val, 32'h25A);
    wr(ra(0, 5'h00), 32'h0FE);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset();
    s_retired();
    s_dev_tx();
    s_irq();
    s_rmap();
    s_loop();
    print_verdict();
  end
endmodule // spacewire_port_ctrl_status_test
`default_nettype wire
